//--- shared/timer2_pkg.sv
package timer2_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] CTRL_ADDR = 8'hC8;
    localparam logic [7:0] CAP_LOW_ADDR = 8'hCA;
    localparam logic [7:0] CAP_HIGH_ADDR = 8'hCB;
    localparam logic [7:0] CNT_LOW_ADDR = 8'hCC;
    localparam logic [7:0] CNT_HIGH_ADDR = 8'hCD;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_ONE = 16'h0001;

    // ****************************************
    // prescale counts
    // ****************************************
    localparam logic [3:0] DIV12_LAST = 4'hB;
    localparam logic [3:0] DIV_ZERO = 4'h0;
    localparam logic [3:0] DIV_ONE = 4'h1;

    typedef struct packed {
        logic overflow_flag;
        logic ext_event_flag;
        logic rx_baud_select;
        logic tx_baud_select;
        logic ext_trigger_enable;
        logic run_control;
        logic counter_select;
        logic capture_reload_select;
    } timer_two_control_t;

    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_CAPTURE = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_BAUD = 2'b11
    } t2_mode_t;

    typedef struct packed {
        logic rx_tick;
        logic tx_tick;
    } baud_ticks_t;

endpackage

//--- rtl/timer2_capture_reload_baud.sv
`timescale 1ns/10ps
// Functional notes
// RULE1: mode from baud selects, run, capture select
// RULE2: timer clock divide one/twelve or pin edges
// RULE3: capture mode trigger latches count, flags event
// RULE4: trigger ignored when trigger enable clear
// RULE5: capture mode wrap sets overflow flag
// RULE6: reload mode wrap sets flag, reloads count
// RULE7: reload mode trigger reloads, sets event flag
// RULE8: run bit starts, clear holds count
// RULE9: baud select forces reload, ignores capture select
// RULE10: baud wrap reloads, ticks uart, no flag
// RULE11: baud timer mode counts at half clock
// RULE12: baud counter mode counts pin edges
// RULE13: baud trigger sets event flag only
// RULE14: baud selects route timer two or one
// RULE15: routing only in uart modes one, three
// RULE16: flags cleared only by software write
// RULE17: either flag plus enable raises interrupt
// RULE18: control reg eight bits, reset zero, layout
// RULE19: event output for converter start
// RULE20: pins synchronised, falling edge single pulse
module timer2_capture_reload_baud
    import timer2_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // special function register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_wr_i,
    output logic [7:0] sfr_rdata_o,
    // system controls
    input wire logic prescale_select_i,
    input wire logic timer2_irq_enable_i,
    input wire logic uart_variable_mode_i,
    input wire logic timer1_overflow_i,
    // pins
    input wire logic count_input_pin_i,
    input wire logic ext_trigger_pin_i,
    // outputs
    output baud_ticks_t baud_ticks_o,
    output logic irq_o,
    output logic adc_start_o
);

    // ****************************************
    // state
    // ****************************************
    timer_two_control_t ctrl_reg;
    logic [15:0] count_reg;
    logic [15:0] capture_reg;
    logic [3:0] div_reg;
    logic [1:0] cnt_sync_reg;
    logic [1:0] trg_sync_reg;
    logic cnt_last_reg;
    logic trg_last_reg;
    logic t2_ovf_tick_reg;
    baud_ticks_t ticks_reg;
    logic irq_reg;
    logic adc_start_reg;
    t2_mode_t mode;
    logic cnt_fall;
    logic trg_fall;
    logic inc_en;
    logic wrap;
    logic trig_evt;
    logic ctrl_wr;

    // ****************************************
    // pin synchronisers
    // ****************************************
    // RULE20: two-stage sync, edge detect
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_sync_reg <= 2'b11;
            trg_sync_reg <= 2'b11;
            cnt_last_reg <= 1'b1;
            trg_last_reg <= 1'b1;
        end else begin
            cnt_sync_reg <= {cnt_sync_reg[0], count_input_pin_i};
            trg_sync_reg <= {trg_sync_reg[0], ext_trigger_pin_i};
            cnt_last_reg <= cnt_sync_reg[1];
            trg_last_reg <= trg_sync_reg[1];
        end
    end

    assign cnt_fall = cnt_last_reg & ~cnt_sync_reg[1];
    assign trg_fall = trg_last_reg & ~trg_sync_reg[1];

    // ****************************************
    // mode decode
    // ****************************************
    // RULE1: mode selection
    always_comb begin
        if (!ctrl_reg.run_control) begin
            mode = MODE_OFF;
        // RULE9: baud overrides capture select
        end else if (ctrl_reg.rx_baud_select || ctrl_reg.tx_baud_select) begin
            mode = MODE_BAUD;
        end else if (ctrl_reg.capture_reload_select) begin
            mode = MODE_CAPTURE;
        end else begin
            mode = MODE_RELOAD;
        end
    end

    // ****************************************
    // prescaler
    // ****************************************
    // prescaler free-runs so the divide phase is not software-visible
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_reg <= DIV_ZERO;
        end else if (mode == MODE_BAUD) begin
            div_reg <= (div_reg == DIV_ZERO) ? DIV_ONE : DIV_ZERO;
        end else if (div_reg >= DIV12_LAST) begin
            div_reg <= DIV_ZERO;
        end else begin
            div_reg <= div_reg + DIV_ONE;
        end
    end

    // RULE2: clock source select
    // RULE11: baud timebase is half clock
    // RULE12: baud counter mode uses pin edges
    always_comb begin
        if (mode == MODE_OFF) begin
            inc_en = 1'b0;
        end else if (ctrl_reg.counter_select) begin
            inc_en = cnt_fall;
        end else if (mode == MODE_BAUD) begin
            inc_en = (div_reg == DIV_ONE);
        end else if (prescale_select_i) begin
            inc_en = 1'b1;
        end else begin
            inc_en = (div_reg == DIV12_LAST);
        end
    end

    assign wrap = inc_en && (count_reg == COUNT_MAX);
    // RULE4: trigger gated by enable
    assign trig_evt = trg_fall && ctrl_reg.ext_trigger_enable && (mode != MODE_OFF);
    assign ctrl_wr = sfr_wr_i && (sfr_addr_i == CTRL_ADDR);

    // ****************************************
    // counter
    // ****************************************
    // RULE8: run holds count when clear
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_reg <= {BYTE_RESET, BYTE_RESET};
        end else if (sfr_wr_i && sfr_addr_i == CNT_LOW_ADDR) begin
            count_reg[7:0] <= sfr_wdata_i;
        end else if (sfr_wr_i && sfr_addr_i == CNT_HIGH_ADDR) begin
            count_reg[15:8] <= sfr_wdata_i;
        // RULE7: trigger reload in reload mode
        end else if (trig_evt && mode == MODE_RELOAD) begin
            count_reg <= capture_reg;
        // RULE6: reload on wrap
        // RULE10: baud wrap reloads
        end else if (wrap && (mode == MODE_RELOAD || mode == MODE_BAUD)) begin
            count_reg <= capture_reg;
        // RULE5: capture mode continues from zero
        end else if (inc_en) begin
            count_reg <= count_reg + COUNT_ONE;
        end
    end

    // ****************************************
    // capture registers
    // ****************************************
    // RULE3: latch count on trigger
    // RULE13: baud trigger does not capture
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            capture_reg <= {BYTE_RESET, BYTE_RESET};
        end else if (trig_evt && mode == MODE_CAPTURE) begin
            capture_reg <= count_reg;
        end else if (sfr_wr_i && sfr_addr_i == CAP_LOW_ADDR) begin
            capture_reg[7:0] <= sfr_wdata_i;
        end else if (sfr_wr_i && sfr_addr_i == CAP_HIGH_ADDR) begin
            capture_reg[15:8] <= sfr_wdata_i;
        end
    end

    // ****************************************
    // control register
    // ****************************************
    // RULE18: control layout and reset
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_reg <= CTRL_RESET;
        end else begin
            if (ctrl_wr) begin
                ctrl_reg <= sfr_wdata_i;
            end
            // RULE16: hardware sets only; set beats clear
            // RULE5: overflow flag outside baud mode
            if (wrap && (mode == MODE_CAPTURE || mode == MODE_RELOAD)) begin
                ctrl_reg.overflow_flag <= 1'b1;
            end
            if (trig_evt) begin
                ctrl_reg.ext_event_flag <= 1'b1;
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            t2_ovf_tick_reg <= 1'b0;
            adc_start_reg <= 1'b0;
        end else begin
            t2_ovf_tick_reg <= wrap && (mode == MODE_BAUD);
            // RULE19: converter start on any overflow
            adc_start_reg <= wrap;
        end
    end

    // RULE14: per-direction routing
    // RULE15: only in variable-rate uart modes
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ticks_reg <= '0;
        end else if (!uart_variable_mode_i) begin
            ticks_reg <= '0;
        end else begin
            ticks_reg.rx_tick <= ctrl_reg.rx_baud_select ? t2_ovf_tick_reg : timer1_overflow_i;
            ticks_reg.tx_tick <= ctrl_reg.tx_baud_select ? t2_ovf_tick_reg : timer1_overflow_i;
        end
    end

    // RULE17: shared interrupt request
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= timer2_irq_enable_i
                && (ctrl_reg.overflow_flag || ctrl_reg.ext_event_flag);
        end
    end

    always_comb begin
        if (sfr_addr_i == CTRL_ADDR) begin
            sfr_rdata_o = ctrl_reg;
        end else if (sfr_addr_i == CAP_LOW_ADDR) begin
            sfr_rdata_o = capture_reg[7:0];
        end else if (sfr_addr_i == CAP_HIGH_ADDR) begin
            sfr_rdata_o = capture_reg[15:8];
        end else if (sfr_addr_i == CNT_LOW_ADDR) begin
            sfr_rdata_o = count_reg[7:0];
        end else if (sfr_addr_i == CNT_HIGH_ADDR) begin
            sfr_rdata_o = count_reg[15:8];
        end else begin
            sfr_rdata_o = BYTE_RESET;
        end
    end

    assign baud_ticks_o = ticks_reg;
    assign irq_o = irq_reg;
    assign adc_start_o = adc_start_reg;

    // ****************************************
    // checks
    // ****************************************
    chk_capture_latch: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE3
        (trig_evt && mode == MODE_CAPTURE) |=> (capture_reg == $past(count_reg)))
        else $error("capture did not latch count");
    chk_trig_ignored: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE4
        (!ctrl_reg.ext_trigger_enable && !ctrl_wr && !ctrl_reg.ext_event_flag)
        |=> !ctrl_reg.ext_event_flag)
        else $error("event flag set with trigger disabled");
    chk_ovf_flag: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE5
        (wrap && mode == MODE_CAPTURE) |=> (ctrl_reg.overflow_flag && count_reg == '0))
        else $error("capture wrap missed flag");
    chk_reload_wrap: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE6
        (wrap && mode == MODE_RELOAD && !trig_evt && !sfr_wr_i)
        |=> (count_reg == $past(capture_reg)))
        else $error("reload on wrap failed");
    chk_run_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE8
        (!ctrl_reg.run_control && !sfr_wr_i) |=> $stable(count_reg))
        else $error("count moved while stopped");
    chk_baud_noflag: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE10
        (wrap && mode == MODE_BAUD && !ctrl_reg.overflow_flag && !ctrl_wr)
        |=> (!ctrl_reg.overflow_flag && t2_ovf_tick_reg))
        else $error("baud overflow set flag");
    chk_baud_half: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE11
        (inc_en && mode == MODE_BAUD && !ctrl_reg.counter_select && $stable(mode))
        |=> !inc_en)
        else $error("baud timebase faster than half clock");
    chk_irq_level: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE17
        (timer2_irq_enable_i && (ctrl_reg.overflow_flag || ctrl_reg.ext_event_flag))
        |=> irq_o)
        else $error("interrupt not raised");
    chk_flag_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE16
        (ctrl_reg.overflow_flag && !ctrl_wr) |=> ctrl_reg.overflow_flag)
        else $error("flag cleared without write");
    chk_mode_decode: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE1
        (ctrl_reg.run_control && !ctrl_reg.rx_baud_select && !ctrl_reg.tx_baud_select)
        |-> (mode == (ctrl_reg.capture_reload_select ? MODE_CAPTURE : MODE_RELOAD)))
        else $error("mode decode wrong");
    chk_div12_gap: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE2
        (inc_en && (mode == MODE_CAPTURE || mode == MODE_RELOAD) && !ctrl_reg.counter_select
            && !prescale_select_i)
        |=> (!inc_en || mode == MODE_BAUD || ctrl_reg.counter_select || prescale_select_i) [*8])
        else $error("divide by twelve timebase too fast");
    chk_reload_trig: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE7
        (trig_evt && mode == MODE_RELOAD && !sfr_wr_i)
        |=> (count_reg == $past(capture_reg) && ctrl_reg.ext_event_flag))
        else $error("trigger reload failed");
    chk_baud_reload: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE9
        (wrap && ctrl_reg.capture_reload_select && mode == MODE_BAUD && !sfr_wr_i)
        |=> (count_reg == $past(capture_reg)))
        else $error("baud wrap did not reload");
    chk_pin_count: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE12
        (cnt_fall && mode == MODE_BAUD && ctrl_reg.counter_select && !sfr_wr_i
            && count_reg != COUNT_MAX)
        |=> (count_reg == $past(count_reg) + COUNT_ONE))
        else $error("baud counter missed pin edge");
    chk_baud_event: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE13
        (trig_evt && mode == MODE_BAUD && !sfr_wr_i)
        |=> (ctrl_reg.ext_event_flag && $stable(capture_reg)))
        else $error("baud trigger misbehaved");
    chk_tick_route: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE14
        (uart_variable_mode_i && !ctrl_reg.tx_baud_select && timer1_overflow_i)
        |=> baud_ticks_o.tx_tick)
        else $error("timer one tick not routed");
    chk_uart_gate: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE15
        !uart_variable_mode_i
        |=> (!baud_ticks_o.rx_tick && !baud_ticks_o.tx_tick))
        else $error("tick outside variable rate mode");
    chk_adc_start: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE19
        wrap
        |=> adc_start_o)
        else $error("converter start missing");
    chk_cnt_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE20
        cnt_fall |=> !cnt_fall)
        else $error("count edge pulse stretched");
    chk_trg_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE20
        trg_fall |=> !trg_fall)
        else $error("trigger edge pulse stretched");

endmodule

//--- test/pin_model.sv
`timescale 1ns/10ps
module pin_model (
    // clock
    input wire logic clk_i,
    // pins, idle high
    output logic count_pin_o,
    output logic trig_pin_o
);
    initial begin
        count_pin_o = 1'b1;
        trig_pin_o = 1'b1;
    end

    task automatic fall(input bit trig);
        @(negedge clk_i);
        if (trig) begin
            trig_pin_o = 1'b0;
        end else begin
            count_pin_o = 1'b0;
        end
        repeat (3) @(negedge clk_i);
        trig_pin_o = 1'b1;
        count_pin_o = 1'b1;
        // settle time covers detect, flag and irq stages
        repeat (6) @(negedge clk_i);
    endtask
endmodule

//--- test/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
    import timer2_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic [7:0] rdata;
    logic irq_en = 1'b1;
    logic t1_ovf = 1'b0;
    logic psel = 1'b0;
    logic uvar = 1'b1;
    logic cpin;
    logic tpin;
    baud_ticks_t ticks;
    logic irq;
    logic adc;
    logic [7:0] m_ctl = 8'h00;
    int mismatches = 0;
    int checked = 0;
    int rx_n = 0, tx_n = 0, adc_n = 0, rx_e = 0, tx_e = 0, adc_e = 0;
    int m_cnt = 0, m_cap = 0, rv, k;

    always #2 clk = ~clk;

    pin_model i_pins (.clk_i(clk), .count_pin_o(cpin), .trig_pin_o(tpin));

    timer2_capture_reload_baud i_dut (
        .core_clk_i(clk), .rst_b_i(rst_b), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
        .sfr_wr_i(wr), .sfr_rdata_o(rdata), .prescale_select_i(psel),
        .timer2_irq_enable_i(irq_en), .uart_variable_mode_i(uvar),
        .timer1_overflow_i(t1_ovf), .count_input_pin_i(cpin), .ext_trigger_pin_i(tpin),
        .baud_ticks_o(ticks), .irq_o(irq), .adc_start_o(adc)
    );

    always @(posedge clk) begin
        if (rst_b) begin
            rx_n += ticks.rx_tick;
            tx_n += ticks.tx_tick;
            adc_n += adc;
        end
    end

    // ****************************************
    // bus tasks and reference model
    // ****************************************
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        case (a)
            CTRL_ADDR: m_ctl = d;
            CAP_LOW_ADDR: m_cap[7:0] = d;
            CAP_HIGH_ADDR: m_cap[15:8] = d;
            CNT_LOW_ADDR: m_cnt[7:0] = d;
            CNT_HIGH_ADDR: m_cnt[15:8] = d;
            default: ;
        endcase
    endtask

    task automatic w16(input logic [7:0] a, input int v);
        wr8(a, v[7:0]);
        wr8(a + 8'h01, v[15:8]);
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        #1;
        `CHK(rdata, e)
    endtask

    task automatic check_all;
        chk_reg(CTRL_ADDR, m_ctl);
        chk_reg(CAP_LOW_ADDR, m_cap[7:0]);
        chk_reg(CAP_HIGH_ADDR, m_cap[15:8]);
        chk_reg(CNT_LOW_ADDR, m_cnt[7:0]);
        chk_reg(CNT_HIGH_ADDR, m_cnt[15:8]);
        `CHK(irq, (m_ctl[7] | m_ctl[6]) & irq_en)
        `CHK(rx_n, rx_e)
        `CHK(tx_n, tx_e)
        `CHK(adc_n, adc_e)
    endtask

    task automatic count_pulse;
        i_pins.fall(1'b0);
        if (m_ctl[2]) begin
            if (m_cnt == 65535) begin
                adc_e++;
                if (m_ctl[5] | m_ctl[4]) begin
                    m_cnt = m_cap;
                    rx_e += m_ctl[5];
                    tx_e += m_ctl[4];
                end else begin
                    m_ctl[7] = 1'b1;
                    m_cnt = m_ctl[0] ? 0 : m_cap;
                end
            end else begin
                m_cnt++;
            end
        end
    endtask

    task automatic trig;
        i_pins.fall(1'b1);
        if (m_ctl[3] & m_ctl[2]) begin
            m_ctl[6] = 1'b1;
            if (!(m_ctl[5] | m_ctl[4])) begin
                if (m_ctl[0]) begin
                    m_cap = m_cnt;
                end else begin
                    m_cnt = m_cap;
                end
            end
        end
    endtask

    // any window of whole timebase periods holds an exact number of steps
    task automatic rate_chk(input logic [7:0] ctl, input int n, input int e);
        logic [7:0] v1;
        w16(CNT_LOW_ADDR, 0);
        wr8(CTRL_ADDR, ctl);
        @(negedge clk);
        addr = CNT_LOW_ADDR;
        #1;
        v1 = rdata;
        repeat (n) @(negedge clk);
        #1;
        `CHK(8'(rdata - v1), e)
        wr8(CTRL_ADDR, 8'h00);
    endtask

    task automatic close_out;
        if (mismatches == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        void'($urandom(32'h8e98dd91));
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        check_all;
        chk_reg(8'hC9, 8'h00);
        wr8(CTRL_ADDR, 8'h0B);
        check_all;
        w16(CNT_LOW_ADDR, 16'hFFFE);
        wr8(CTRL_ADDR, 8'h0F);
        repeat (3) count_pulse;
        check_all;
        trig;
        check_all;
        irq_en = 1'b0;
        check_all;
        irq_en = 1'b1;
        wr8(CTRL_ADDR, 8'h07);
        trig;
        check_all;
        rv = $urandom_range(16'hFFF0, 0);
        k = $urandom_range(4, 1);
        w16(CAP_LOW_ADDR, rv);
        w16(CNT_LOW_ADDR, 65536 - k);
        wr8(CTRL_ADDR, 8'h0E);
        repeat (k + 2) count_pulse;
        check_all;
        trig;
        check_all;
        wr8(CTRL_ADDR, 8'h0A);
        count_pulse;
        check_all;
        wr8(CTRL_ADDR, 8'h3F);
        w16(CNT_LOW_ADDR, 16'hFFFF);
        repeat (2) count_pulse;
        check_all;
        trig;
        check_all;
        wr8(CTRL_ADDR, 8'h26);
        w16(CNT_LOW_ADDR, 16'hFFFF);
        count_pulse;
        @(negedge clk);
        t1_ovf = 1'b1;
        @(negedge clk);
        t1_ovf = 1'b0;
        tx_e++;
        repeat (3) @(negedge clk);
        check_all;
        rate_chk(8'h04, 24, 2);
        rate_chk(8'h34, 20, 10);
        psel = 1'b1;
        rate_chk(8'h04, 20, 20);
        psel = 1'b0;
        uvar = 1'b0;
        @(negedge clk);
        t1_ovf = 1'b1;
        @(negedge clk);
        t1_ovf = 1'b0;
        repeat (3) @(negedge clk);
        `CHK(tx_n, tx_e)
        close_out;
    end

    initial begin
        #20000;
        mismatches++;
        close_out;
    end
endmodule
